// [swt_consts.svh]
/*
 Constants of the watchdog configuration link: I/O ports, keys, register
 indices, field positions, reset values, timing and host APB map.
 Assumes inclusion by bare name from each file that needs it.
*/
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH

`define SWT_PORT_INDEX 16'h002e
`define SWT_PORT_DATA 16'h002f
`define SWT_KEY_UNLOCK 8'h87
`define SWT_KEY_LOCK 8'haa

`define SWT_REG_LDN 8'h07
`define SWT_REG_ACT 8'h30
`define SWT_REG_UNIT 8'hf0
`define SWT_REG_COUNT 8'hf1
`define SWT_REG_CTRL 8'hf2
`define SWT_LDN_WDT 8'h08
`define SWT_ACT_ON 8'h01

`define SWT_UNIT_BIT 3
`define SWT_MOUSE_BIT 7
`define SWT_KBD_BIT 6
`define SWT_FORCE_BIT 5
`define SWT_STAT_BIT 4

`define SWT_LDN_RST 8'h00
`define SWT_COUNT_RST 8'h00
`define SWT_IDLE_RDATA 8'hff
`define SWT_UNMAPPED_RDATA 8'h00

`define SWT_UNIT_S 1
`define SWT_CLK_HZ 10000000
`define SWT_SEC_PER_MIN 60

`define SWT_APB_CMD 12'h000
`define SWT_APB_STAT 12'h004
`define SWT_CMD_PORT_BIT 8
`define SWT_CMD_WR_BIT 9
`define SWT_CMD_OP_LSB 10
`define SWT_STAT_BUSY_BIT 0
`define SWT_STAT_TMO_BIT 1
`define SWT_STAT_RD_LSB 8

`endif

// [swt_pkg.sv]
/*
 Types shared by both ends of the watchdog link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package swt_pkg;

    typedef enum logic [1:0] {
        SWT_OP_SINGLE,
        SWT_OP_UNLOCK,
        SWT_OP_LOCK
    } swt_op_t;

    typedef enum logic {
        SWT_HS_IDLE,
        SWT_HS_WAIT
    } swt_hfsm_t;

    typedef struct packed {
        logic cfg_on;
        logic key_one;
        logic [7:0] index;
        logic [7:0] ldn;
        logic active;
        logic unit_min;
        logic [7:0] count;
        logic [7:0] remain;
        logic mouse_en;
        logic kbd_en;
        logic expired;
        logic ack;
        logic [7:0] rdata;
    } swt_dev_st_t;

    typedef struct packed {
        swt_hfsm_t fsm;
        logic pready;
        logic [31:0] prdata;
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic left;
        logic [7:0] rdata;
    } swt_host_st_t;

endpackage : swt_pkg

// [swt_io_if.sv]
/*
 I/O cycle link between the host end and the watchdog device.
 Assumes both ends run on the same clock; one request pulse, one ack pulse.
*/
`timescale 1ns/100ps
`default_nettype none

interface swt_io_if;
    logic io_req;
    logic io_we;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    logic io_ack;
    logic [7:0] io_rdata;
    logic wdt_timeout;

    modport dev (
        input io_req,
        input io_we,
        input io_addr,
        input io_wdata,
        output io_ack,
        output io_rdata,
        output wdt_timeout
    );

    modport host (
        output io_req,
        output io_we,
        output io_addr,
        output io_wdata,
        input io_ack,
        input io_rdata,
        input wdt_timeout
    );
endinterface : swt_io_if

`default_nettype wire

// [swt_tick_div.sv]
/*
 Divider: one tick pulse every DIV enabled cycles, restartable.
 Assumes a synchronous clear from the owner's reload logic.
*/
`timescale 1ns/100ps
`default_nettype none

module swt_tick_div #(
    parameter int unsigned DIV = 10
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic en_i,
    output logic tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } swt_div_st_t;

    swt_div_st_t s_reg;
    swt_div_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (clear_i) begin
            s_next.cnt = '0;
        end else if (en_i) begin
            if (s_reg.cnt == W'(DIV - 1)) begin
                s_next.cnt = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;
endmodule : swt_tick_div

`default_nettype wire

// [swt_device.sv]
/*
 Watchdog device end: index/data configuration ports, unlock and lock keys,
 logical device select, countdown in seconds or minutes, timeout output.
 Assumes the host end keeps the link order: one request, then wait for ack.
*/
// Implementation choice: register access over the index/data I/O link.
`timescale 1ns/100ps
`default_nettype none
`include "swt_consts.svh"

module swt_device #(
    parameter int unsigned TICK_CYCLES = `SWT_UNIT_S * `SWT_CLK_HZ,
    parameter int unsigned UNITS_PER_MIN = `SWT_SEC_PER_MIN
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    swt_io_if.dev io,
    input wire logic mouse_act_i,
    input wire logic kbd_act_i,
    output logic timeout_o,
    output logic timeout_status_o
);
    swt_pkg::swt_dev_st_t s_reg;
    swt_pkg::swt_dev_st_t s_next;

    logic div_clear;
    logic sec_tick;
    logic min_tick;
    logic unit_tick;
    logic wr_index;
    logic data_acc;
    logic wdt_sel;
    logic running;
    logic reload;
    logic [7:0] rd_value;

    // Restart on reload so the first unit after a strobe is a full one
    swt_tick_div #(
        .DIV(TICK_CYCLES)
    ) u_sec_div (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(div_clear),
        .en_i(running),
        .tick_o(sec_tick)
    );

    swt_tick_div #(
        .DIV(UNITS_PER_MIN)
    ) u_min_div (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(div_clear),
        .en_i(sec_tick),
        .tick_o(min_tick)
    );

    assign unit_tick = s_reg.unit_min ? min_tick : sec_tick;

    // Read mux of the indexed register
    always_comb begin
        rd_value = `SWT_UNMAPPED_RDATA;
        if (s_reg.index == `SWT_REG_LDN) begin
            rd_value = s_reg.ldn;
        end else if (wdt_sel) begin
            case (s_reg.index)
                `SWT_REG_ACT: begin
                    rd_value = {7'h00, s_reg.active};
                end
                `SWT_REG_UNIT: begin
                    rd_value[`SWT_UNIT_BIT] = s_reg.unit_min;
                end
                `SWT_REG_COUNT: begin
                    rd_value = s_reg.count;
                end
                `SWT_REG_CTRL: begin
                    rd_value[`SWT_MOUSE_BIT] = s_reg.mouse_en;
                    rd_value[`SWT_KBD_BIT] = s_reg.kbd_en;
                    rd_value[`SWT_STAT_BIT] = s_reg.expired;
                end
                default: begin
                    rd_value = `SWT_UNMAPPED_RDATA;
                end
            endcase
        end
    end

    assign wr_index = io.io_req && io.io_we && (io.io_addr == `SWT_PORT_INDEX);
    assign data_acc = io.io_req && (io.io_addr == `SWT_PORT_DATA) && s_reg.cfg_on;
    assign wdt_sel = (s_reg.ldn == `SWT_LDN_WDT);
    assign running = s_reg.active && (s_reg.count != 8'h00) && !s_reg.expired;
    assign reload = running && ((mouse_act_i && s_reg.mouse_en) || (kbd_act_i && s_reg.kbd_en));

    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        div_clear = 1'b0;
        if (io.io_req) begin
            // Every cycle is answered; a locked device reads all ones
            s_next.ack = 1'b1;
            s_next.rdata = `SWT_IDLE_RDATA;
        end
        if (wr_index) begin
            if (!s_reg.cfg_on) begin
                if (io.io_wdata == `SWT_KEY_UNLOCK) begin
                    s_next.cfg_on = s_reg.key_one;
                    s_next.key_one = !s_reg.key_one;
                end else begin
                    s_next.key_one = 1'b0;
                end
            end else if (io.io_wdata == `SWT_KEY_LOCK) begin
                s_next.cfg_on = 1'b0;
                s_next.key_one = 1'b0;
            end else begin
                s_next.index = io.io_wdata;
            end
        end else if (io.io_req && !s_reg.cfg_on) begin
            // Any other cycle breaks a half-done unlock
            s_next.key_one = 1'b0;
        end
        if (data_acc && !io.io_we) begin
            s_next.rdata = rd_value;
        end
        if (data_acc && io.io_we) begin
            if (s_reg.index == `SWT_REG_LDN) begin
                s_next.ldn = io.io_wdata;
            end else if (wdt_sel) begin
                case (s_reg.index)
                    `SWT_REG_ACT: begin
                        s_next.active = (io.io_wdata == `SWT_ACT_ON);
                    end
                    `SWT_REG_UNIT: begin
                        s_next.unit_min = io.io_wdata[`SWT_UNIT_BIT];
                    end
                    `SWT_REG_COUNT: begin
                        s_next.count = io.io_wdata;
                        s_next.remain = io.io_wdata;
                        s_next.expired = 1'b0;
                        div_clear = 1'b1;
                    end
                    `SWT_REG_CTRL: begin
                        s_next.mouse_en = io.io_wdata[`SWT_MOUSE_BIT];
                        s_next.kbd_en = io.io_wdata[`SWT_KBD_BIT];
                        // Force bit is not stored, so it always reads back 0
                        if (io.io_wdata[`SWT_FORCE_BIT]) begin
                            s_next.expired = 1'b1;
                        end
                    end
                    default: begin
                        s_next.index = s_reg.index;
                    end
                endcase
            end
        end
        if (reload) begin
            s_next.remain = s_reg.count;
            div_clear = 1'b1;
        end else if (running && unit_tick) begin
            if (s_reg.remain <= 8'h01) begin
                // Expiry placed last: it wins over a clear in the same cycle
                s_next.remain = 8'h00;
                s_next.expired = 1'b1;
            end else begin
                s_next.remain = s_reg.remain - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
            s_reg.ldn <= `SWT_LDN_RST;
            s_reg.count <= `SWT_COUNT_RST;
            s_reg.remain <= `SWT_COUNT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign io.io_ack = s_reg.ack;
    assign io.io_rdata = s_reg.rdata;
    assign io.wdt_timeout = s_reg.expired;
    assign timeout_o = s_reg.expired;
    assign timeout_status_o = s_reg.expired;
endmodule : swt_device

`default_nettype wire

// [swt_host.sv]
/*
 Host end: APB slave with a command and a status register; each command
 issues one I/O cycle, or the unlock or lock key sequence, on the link.
 Assumes software orders commands: unlock, select, access, lock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swt_consts.svh"

module swt_host (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    swt_io_if.host io
);
    swt_pkg::swt_host_st_t s_reg;
    swt_pkg::swt_host_st_t s_next;

    logic acc;
    swt_pkg::swt_op_t op;

    assign acc = psel_i && penable_i && !s_reg.pready;
    assign op = swt_pkg::swt_op_t'(pwdata_i[`SWT_CMD_OP_LSB +: 2]);

    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.req = 1'b0;
        if (acc) begin
            // One wait state so read data comes from a flip-flop
            s_next.pready = 1'b1;
            s_next.prdata = 32'h0000_0000;
            if (!pwrite_i && paddr_i == `SWT_APB_STAT) begin
                s_next.prdata[`SWT_STAT_BUSY_BIT] = (s_reg.fsm != swt_pkg::SWT_HS_IDLE);
                s_next.prdata[`SWT_STAT_TMO_BIT] = io.wdt_timeout;
                s_next.prdata[`SWT_STAT_RD_LSB +: 8] = s_reg.rdata;
            end
        end
        unique case (s_reg.fsm)
            swt_pkg::SWT_HS_IDLE: begin
                // Commands while busy are dropped; software polls busy first
                if (acc && pwrite_i && paddr_i == `SWT_APB_CMD) begin
                    s_next.fsm = swt_pkg::SWT_HS_WAIT;
                    s_next.req = 1'b1;
                    s_next.we = 1'b1;
                    s_next.left = 1'b0;
                    s_next.addr = `SWT_PORT_INDEX;
                    case (op)
                        swt_pkg::SWT_OP_SINGLE: begin
                            s_next.we = pwdata_i[`SWT_CMD_WR_BIT];
                            s_next.wdata = pwdata_i[7:0];
                            if (pwdata_i[`SWT_CMD_PORT_BIT]) begin
                                s_next.addr = `SWT_PORT_DATA;
                            end
                        end
                        swt_pkg::SWT_OP_UNLOCK: begin
                            s_next.wdata = `SWT_KEY_UNLOCK;
                            s_next.left = 1'b1;
                        end
                        swt_pkg::SWT_OP_LOCK: begin
                            s_next.wdata = `SWT_KEY_LOCK;
                        end
                        default: begin
                            s_next.fsm = swt_pkg::SWT_HS_IDLE;
                            s_next.req = 1'b0;
                        end
                    endcase
                end
            end
            swt_pkg::SWT_HS_WAIT: begin
                if (io.io_ack) begin
                    if (!s_reg.we) begin
                        s_next.rdata = io.io_rdata;
                    end
                    if (s_reg.left) begin
                        // Second key back to back, nothing in between
                        s_next.left = 1'b0;
                        s_next.req = 1'b1;
                    end else begin
                        s_next.fsm = swt_pkg::SWT_HS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
            s_reg.fsm <= swt_pkg::SWT_HS_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o = s_reg.prdata;
    assign pready_o = s_reg.pready;
    assign pslverr_o = 1'b0;
    assign io.io_req = s_reg.req;
    assign io.io_we = s_reg.we;
    assign io.io_addr = s_reg.addr;
    assign io.io_wdata = s_reg.wdata;
endmodule : swt_host

`default_nettype wire

// [swt_properties.sv]
/*
 Checker for the watchdog link: ack timing, key locking, force, status hold.
 Assumes instantiation beside the link interface; one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module swt_properties (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic io_req,
    input wire logic io_we,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_ack,
    input wire logic [7:0] io_rdata,
    input wire logic wdt_timeout
);
    // Shadow of device mode; only cycles the device accepts move it
    logic lk, k1, act, iw, dw, frc;
    logic [7:0] idx, ldn;
    assign iw = io_req && io_we && io_addr == 16'h002e;
    assign dw = io_req && io_we && io_addr == 16'h002f && !lk && ldn == 8'h08;
    assign frc = dw && idx == 8'hf2 && io_wdata[5];

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {lk, k1, act, idx, ldn} <= {3'b100, 16'h0000};
        end else if (io_req) begin
            k1 <= iw && lk && io_wdata == 8'h87 && !k1;
            if (iw && lk && k1 && io_wdata == 8'h87) lk <= 1'b0;
            if (iw && !lk && io_wdata == 8'haa) lk <= 1'b1;
            if (iw && !lk && io_wdata != 8'haa) idx <= io_wdata;
            if (io_we && io_addr == 16'h002f && !lk && idx == 8'h07) ldn <= io_wdata;
            if (dw && idx == 8'h30) act <= io_wdata == 8'h01;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_rd(logic [15:0] a);
        io_req && !io_we && io_addr == a;
    endsequence
    sequence s_stat_rd;
        !lk && ldn == 8'h08 && idx == 8'hf2 ##0 s_rd(16'h002f);
    endsequence

    property p_ack;
        io_req |=> io_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack_cause;
        io_ack |-> $past(io_req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_idx_rd;
        s_rd(16'h002e) |=> io_rdata == 8'hff;
    endproperty
    a_idx_rd: assert property (p_idx_rd) else $error("index port read not ff");
    property p_locked;
        lk ##0 s_rd(16'h002f) |=> io_rdata == 8'hff;
    endproperty
    a_locked: assert property (p_locked) else $error("locked data read not ff");
    property p_rd_hold;
        !io_req |=> $stable(io_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_force;
        frc |-> ##[1:2] wdt_timeout;
    endproperty
    a_force: assert property (p_force) else $error("force gave no timeout");
    property p_stat_rd;
        s_stat_rd |=> io_rdata[5:4] == {1'b0, $past(wdt_timeout)};
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("control read bits wrong");
    property p_to_hold;
        wdt_timeout && !(dw && idx == 8'hf1) |=> wdt_timeout;
    endproperty
    a_to_hold: assert property (p_to_hold) else $error("timeout dropped");
    property p_inact;
        !act && !frc |=> !$rose(wdt_timeout);
    endproperty
    a_inact: assert property (p_inact) else $error("timeout while inactive");
endmodule : swt_properties

`default_nettype wire

// [swt_tb.sv]
/*
 Testbench: host end and watchdog device joined by the link, driven over APB.
 Assumes a 10 MHz clock; prescaler shortened to 20 cycles, 3 units a minute.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int TK = 20;
    logic clk_sys_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic mouse_i = 0, kbd_i = 0, pready_o, to_o, ts_o, err_o;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, r;
    logic [7:0] lf = 8'h03;
    logic [7:0] eq[$];
    int miscompares = 0, comparisons = 0;

    swt_io_if i_swt_io_if ();
    swt_host i_swt_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(err_o), .io(i_swt_io_if.host));
    swt_device #(.TICK_CYCLES(TK), .UNITS_PER_MIN(3)) i_swt_device (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .io(i_swt_io_if.dev), .mouse_act_i(mouse_i), .kbd_act_i(kbd_i),
        .timeout_o(to_o), .timeout_status_o(ts_o));
    swt_properties i_swt_properties (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .io_req(i_swt_io_if.io_req), .io_we(i_swt_io_if.io_we), .io_addr(i_swt_io_if.io_addr),
        .io_wdata(i_swt_io_if.io_wdata), .io_ack(i_swt_io_if.io_ack), .io_rdata(i_swt_io_if.io_rdata),
        .wdt_timeout(i_swt_io_if.wdt_timeout));

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Every link read result is matched to the oldest note
    always @(posedge clk_sys_i) begin
        if (i_swt_io_if.io_ack === 1'b1 && i_swt_io_if.io_we === 1'b0) begin
            chk("link read", eq.size() > 0 ? {24'h0, eq.pop_front()} : 32'hx,
                {24'h0, i_swt_io_if.io_rdata});
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        q = prdata_o;
        chk("pslverr", 32'h0, {31'h0, err_o});
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb

    // Busy is polled, since a command written while busy is dropped
    task automatic io(input logic [1:0] op, input logic p, input logic w, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, 12'h000, {20'h0, op, w, p, d}, q);
        do apb(1'b0, 12'h004, 32'h0, q); while (q[0] !== 1'b0);
    endtask : io

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        io(2'd0, 1'b0, 1'b1, a);
        io(2'd0, 1'b1, 1'b1, v);
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        io(2'd0, 1'b0, 1'b1, a);
        eq.push_back(e);
        io(2'd0, 1'b1, 1'b0, 8'h00);
    endtask : rreg

    task automatic tmo(input logic e, input int n);
        logic [31:0] q;
        for (int i = 0; i < n && to_o !== e; i++) @(posedge clk_sys_i);
        apb(1'b0, 12'h004, 32'h0, q);
        chk("timeout flag", {31'h0, e}, {31'h0, q[1]});
        chk("timeout pin", {31'h0, e}, {31'h0, ts_o});
        chk("timeout out", {31'h0, e}, {31'h0, to_o});
    endtask : tmo

    task automatic act(input logic m);
        mouse_i <= m;
        kbd_i <= !m;
        @(posedge clk_sys_i);
        mouse_i <= 1'b0;
        kbd_i <= 1'b0;
    endtask : act

    task automatic end_sim();
        // A read that never got its answer leaves a note behind
        chk("notes left", 32'h0, eq.size());
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        eq.push_back(8'hff);
        io(2'd0, 1'b1, 1'b0, 8'h00);
        eq.push_back(8'hff);
        io(2'd0, 1'b0, 1'b0, 8'h00);
        apb(1'b0, 12'h008, 32'h0, r);
        chk("unmapped apb", 32'h0, r);
        $display("test locked done");
        io(2'd1, 1'b0, 1'b1, 8'h00);
        wreg(8'h07, 8'h08);
        rreg(8'hf0, 8'h00);
        rreg(8'hf1, 8'h00);
        rreg(8'hf2, 8'h00);
        rreg(8'h55, 8'h00);
        lf = lfsr(lf);
        wreg(8'hf1, lf | 8'h80);
        rreg(8'hf1, lf | 8'h80);
        $display("test reset values done");
        wreg(8'h30, 8'h01);
        wreg(8'hf1, 8'h03);
        wt_n(2 * TK);
        tmo(1'b0, 0);
        wreg(8'hf1, 8'h03);
        wt_n(2 * TK);
        tmo(1'b0, 0);
        tmo(1'b1, 2 * TK);
        rreg(8'hf2, 8'h10);
        wt_n(100);
        tmo(1'b1, 0);
        wreg(8'hf1, 8'h00);
        wt_n(100);
        tmo(1'b0, 0);
        $display("test seconds done");
        wreg(8'hf0, 8'h08);
        rreg(8'hf0, 8'h08);
        wreg(8'hf1, 8'h01);
        wt_n(2 * TK);
        tmo(1'b0, 0);
        tmo(1'b1, 2 * TK);
        wreg(8'hf0, 8'h00);
        $display("test minutes done");
        // Enabled source keeps it alive; the other one must not
        for (int b = 0; b < 2; b++) begin
            wreg(8'hf2, b ? 8'h40 : 8'h80);
            wreg(8'hf1, 8'h02);
            repeat (5) begin
                wt_n(TK);
                act(b == 0);
            end
            tmo(1'b0, 0);
            repeat (4) begin
                wt_n(TK);
                act(b != 0);
            end
            tmo(1'b1, 0);
        end
        $display("test activity done");
        wreg(8'hf1, 8'h00);
        wreg(8'hf2, 8'h20);
        tmo(1'b1, 0);
        rreg(8'hf2, 8'h10);
        // Reset in mid-run clears status and locks the device again
        reset_n_i <= 1'b0;
        wt_n(2);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        tmo(1'b0, 0);
        eq.push_back(8'hff);
        io(2'd0, 1'b1, 1'b0, 8'h00);
        io(2'd1, 1'b0, 1'b1, 8'h00);
        wreg(8'h07, 8'h08);
        rreg(8'hf2, 8'h00);
        wreg(8'h30, 8'h00);
        wreg(8'hf1, 8'h01);
        wt_n(3 * TK);
        tmo(1'b0, 0);
        $display("test force and disable done");
        io(2'd2, 1'b0, 1'b1, 8'h00);
        eq.push_back(8'hff);
        io(2'd0, 1'b1, 1'b0, 8'h00);
        io(2'd0, 1'b0, 1'b1, 8'h87);
        eq.push_back(8'hff);
        io(2'd0, 1'b0, 1'b0, 8'h00);
        io(2'd0, 1'b0, 1'b1, 8'h87);
        eq.push_back(8'hff);
        io(2'd0, 1'b1, 1'b0, 8'h00);
        $display("test lock done");
        end_sim();
    end

    task automatic wt_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : wt_n

    // Whole run is under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        end_sim();
    end
endmodule : testbench

`default_nettype wire
